/* File: rtl/cmd_defs.svh */
// Operation
// - Two bank selects pick one row strobe
// - Strap high enters advanced read mode
// - Normal mode: low read request means read cycle
// - Advanced mode: latch status on latch trailing edge
// - Advanced mode: no transparent refresh
// - Low write request means write cycle
// - Requests honoured only while chip select low
// - Chip select loss never aborts cycle
// - Normal mode: high refresh input schedules refresh
// - Transfer acknowledge pulses when data valid
// - System acknowledge marks start of access
// - Access during refresh: acknowledge waits
// - Address bits 14:13 pick ROM, 12:0 pass
// - Three 8K ROMs, one 4K ROM
// - Read strobe and memory select active low
// - System RAM answers only 8000 to BFFF
// - Row bits 6:0, column bits 15:7
// - Bit15 set, bit14 clear selects strobe 2
// - Memory cycle starts only when memory selected
// - Write strobe steers data toward memory
// - Control registers live in I/O space
// - Column strobe latches column address
`ifndef CMD_DEFS_SVH
`define CMD_DEFS_SVH

// ****************************************
// Address map and field positions.
// ****************************************
`define CMD_RAM_WINDOW 2'h2
`define CMD_ROM_IDX_HI 14
`define CMD_ROM_IDX_LO 13
`define CMD_ROM_SMALL_IDX 2'h3
`define CMD_ROM_SMALL_BIT 12
`define CMD_ROM_BIG_KB 8
`define CMD_ROM_SMALL_KB 4
`define CMD_ROW_HI 6
`define CMD_COL_LO 7
`define CMD_REG_IDX_HI 6

// ****************************************
// Timing in nanoseconds and derived cycle counts.
// ****************************************
`define CMD_CLK_NS 100
`define CMD_RAS_CAS_NS 200
`define CMD_CAS_NS 200
`define CMD_REF_NS 300
`define CMD_FIXED_NS 300
`define CMD_REF_PERIOD_NS 15600
`define CMD_RAS_CAS_CYC ((`CMD_RAS_CAS_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)
`define CMD_CAS_CYC ((`CMD_CAS_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)
`define CMD_REF_CYC ((`CMD_REF_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)
`define CMD_FIXED_CYC ((`CMD_FIXED_NS + `CMD_CLK_NS - 1) / `CMD_CLK_NS)
`define CMD_REF_PERIOD_CYC (`CMD_REF_PERIOD_NS / `CMD_CLK_NS)

`endif

/* File: rtl/cmd_pkg.sv */
`default_nettype none
// ****************************************
// Types shared by both ends.
// ****************************************
package cmd_pkg;
   // Controller sequencer states.
   typedef enum logic [2:0] {
      CMD_ST_IDLE = 3'h0,
      CMD_ST_ROW = 3'h1,
      CMD_ST_COL = 3'h2,
      CMD_ST_DONE = 3'h3,
      CMD_ST_WAIT = 3'h4,
      CMD_ST_REF = 3'h5
   } cmd_state_t;

   // Bus master states.
   typedef enum logic [2:0] {
      CMD_H_IDLE = 3'h0,
      CMD_H_ALE = 3'h1,
      CMD_H_MEM = 3'h2,
      CMD_H_FIX = 3'h3,
      CMD_H_END = 3'h4
   } cmd_host_state_t;
endpackage
`default_nettype wire

/* File: rtl/cmd_if.sv */
`default_nettype none
// ****************************************
// Processor side memory bus between master and controller.
// ****************************************
interface cmd_if;
   logic [15:0] addr;
   logic io_m;
   logic read_strobe_n;
   logic write_strobe_n;
   logic read_request_status;
   logic protected_chip_select_n;
   logic refresh_or_latch_in;
   logic bank_select_lo;
   logic bank_select_hi_strap;
   logic transfer_acknowledge;
   logic system_acknowledge;
   logic [3:0] row_strobe_n;
   logic col_strobe_n;
   logic write_enable_n;
   logic [8:0] dram_addr;
   logic [3:0] rom_select_n;
   logic [12:0] rom_addr;
   logic data_dir_to_mem;
   logic data_gate_to_cpu;

   // Controller end.
   modport ctrl (
      input addr, io_m, read_strobe_n, write_strobe_n, read_request_status,
      input protected_chip_select_n, refresh_or_latch_in, bank_select_lo,
      input bank_select_hi_strap,
      output transfer_acknowledge, system_acknowledge, row_strobe_n, col_strobe_n,
      output write_enable_n, dram_addr, rom_select_n, rom_addr, data_dir_to_mem,
      output data_gate_to_cpu
   );

   // Processor end.
   modport master (
      output addr, io_m, read_strobe_n, write_strobe_n, read_request_status,
      output protected_chip_select_n, refresh_or_latch_in, bank_select_lo,
      output bank_select_hi_strap,
      input transfer_acknowledge, system_acknowledge, row_strobe_n, col_strobe_n,
      input write_enable_n, dram_addr, rom_select_n, rom_addr, data_dir_to_mem,
      input data_gate_to_cpu
   );
endinterface
`default_nettype wire

/* File: rtl/cmd_ctrl.sv */
`include "cmd_defs.svh"
`default_nettype none
// ****************************************
// Dynamic RAM controller with ROM and I/O decode.
// ****************************************
module cmd_ctrl (
   input wire logic mclk,
   input wire logic srst,
   cmd_if.ctrl bus,
   input wire logic advanced_strap,
   output logic advanced_mode,
   output logic io_reg_wr,
   output logic io_reg_rd,
   output logic [6:0] io_reg_index
);

   // ****************************************
   // Declarations.
   // ****************************************
   cmd_pkg::cmd_state_t st;
   logic strap_meta, strap_sync, ale_prev, status_latched, ref_pend, system_acknowledge_late, is_write;
   logic [2:0] cnt;
   logic [15:0] acc_addr;
   logic ale_fall, in_window, mem_sel, rd_req, wr_req, acc_req, ref_req;
   logic start_acc, start_ref, rom_hit;
   logic [1:0] rom_idx;

   // Turns a two bit index into a one-hot select.
   function automatic logic [3:0] one_hot(input logic [1:0] idx);
      return 4'h1 << idx;
   endfunction

   // ****************************************
   // Mode strap.
   // ****************************************
   // Strap synchronised to mclk.
   always_ff @(posedge mclk) begin
      strap_meta <= advanced_strap;
      strap_sync <= strap_meta;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         advanced_mode <= strap_sync;
      end
   end

   // ****************************************
   // Request decode.
   // ****************************************
   // Trailing edge of the latch strobe, only meaningful in advanced mode.
   assign ale_fall = advanced_mode & ale_prev & ~bus.refresh_or_latch_in;
   assign in_window = bus.addr[15:14] == `CMD_RAM_WINDOW;
   assign mem_sel = ~bus.io_m & ~bus.protected_chip_select_n & in_window;
   assign rd_req = advanced_mode ? status_latched : ~bus.read_request_status;
   assign wr_req = ~bus.write_strobe_n;
   assign acc_req = mem_sel & (rd_req | wr_req);
   assign ref_req = ~advanced_mode & bus.refresh_or_latch_in;
   assign start_ref = (st == cmd_pkg::CMD_ST_IDLE) & ref_pend;
   assign start_acc = (st == cmd_pkg::CMD_ST_IDLE) & ~ref_pend & acc_req;

   // Previous latch strobe level for edge detection.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ale_prev <= 1'b0;
      end else begin
         ale_prev <= bus.refresh_or_latch_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         status_latched <= 1'b0;
      end else if (ale_fall) begin
         status_latched <= bus.read_request_status;
      end else if (start_acc & ~wr_req) begin
         status_latched <= 1'b0;
      end
   end

   // A new refresh request wins over the clear on refresh entry.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_pend <= 1'b0;
      end else if (ref_req) begin
         ref_pend <= 1'b1;
      end else if (start_ref) begin
         ref_pend <= 1'b0;
      end
   end

   // ****************************************
   // Sequencer.
   // ****************************************
   // Once started a cycle runs to its end whatever the select does.
   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= cmd_pkg::CMD_ST_IDLE;
         cnt <= 3'h0;
      end else begin
         case (st)
            cmd_pkg::CMD_ST_IDLE: begin
               if (start_ref) begin
                  st <= cmd_pkg::CMD_ST_REF;
                  cnt <= 3'(`CMD_REF_CYC - 1);
               end else if (start_acc) begin
                  st <= cmd_pkg::CMD_ST_ROW;
                  cnt <= 3'(`CMD_RAS_CAS_CYC - 1);
               end
            end
            cmd_pkg::CMD_ST_ROW: begin
               if (cnt == 3'h0) begin
                  st <= cmd_pkg::CMD_ST_COL;
                  cnt <= 3'(`CMD_CAS_CYC - 1);
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            cmd_pkg::CMD_ST_COL: begin
               if (cnt == 3'h0) begin
                  st <= cmd_pkg::CMD_ST_DONE;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            cmd_pkg::CMD_ST_DONE: begin
               st <= cmd_pkg::CMD_ST_WAIT;
            end
            cmd_pkg::CMD_ST_WAIT: begin
               if (~rd_req & ~wr_req) begin
                  st <= cmd_pkg::CMD_ST_IDLE;
               end
            end
            cmd_pkg::CMD_ST_REF: begin
               if (cnt == 3'h0) begin
                  st <= cmd_pkg::CMD_ST_IDLE;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            default: begin
               st <= cmd_pkg::CMD_ST_IDLE;
            end
         endcase
      end
   end

   // Direction and address captured at cycle start.
   always_ff @(posedge mclk) begin
      if (srst) begin
         is_write <= 1'b0;
         acc_addr <= 16'h0000;
      end else if (start_acc) begin
         is_write <= wr_req;
         acc_addr <= bus.addr;
      end
   end

   // Access seen during refresh delays the acknowledge.
   always_ff @(posedge mclk) begin
      if (srst) begin
         system_acknowledge_late <= 1'b0;
      end else if (st == cmd_pkg::CMD_ST_REF && acc_req) begin
         system_acknowledge_late <= 1'b1;
      end else if (st == cmd_pkg::CMD_ST_COL && cnt == 3'h0) begin
         system_acknowledge_late <= 1'b0;
      end
   end

   // ****************************************
   // DRAM pins.
   // ****************************************
   // Row strobe per bank, low pair off in advanced mode.
   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.row_strobe_n <= 4'hF;
      end else if (start_ref) begin
         bus.row_strobe_n <= advanced_mode ? 4'hF : 4'h0;
      end else if (start_acc) begin
         bus.row_strobe_n <= ~(one_hot({bus.bank_select_hi_strap, bus.bank_select_lo})
            & (advanced_mode ? 4'hC : 4'hF));
      end else if (st == cmd_pkg::CMD_ST_DONE ||
            (st == cmd_pkg::CMD_ST_REF && cnt == 3'h0)) begin
         bus.row_strobe_n <= 4'hF;
      end
   end

   // Row then column address with column strobe.
   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.dram_addr <= 9'h000;
         bus.col_strobe_n <= 1'b1;
         bus.write_enable_n <= 1'b1;
      end else if (start_acc) begin
         bus.dram_addr <= {2'h0, bus.addr[`CMD_ROW_HI:0]};
      end else if (st == cmd_pkg::CMD_ST_ROW && cnt == 3'h0) begin
         bus.dram_addr <= acc_addr[15:`CMD_COL_LO];
         bus.col_strobe_n <= 1'b0;
         bus.write_enable_n <= ~is_write;
      end else if (st == cmd_pkg::CMD_ST_COL && cnt == 3'h0) begin
         bus.col_strobe_n <= 1'b1;
         bus.write_enable_n <= 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.transfer_acknowledge <= 1'b0;
         bus.system_acknowledge <= 1'b0;
      end else begin
         bus.transfer_acknowledge <= st == cmd_pkg::CMD_ST_COL && cnt == 3'h0;
         bus.system_acknowledge <= (start_acc & ~system_acknowledge_late) |
            (st == cmd_pkg::CMD_ST_COL && cnt == 3'h0 && system_acknowledge_late);
      end
   end

   // ****************************************
   // ROM, data buffer and I/O decode.
   // ****************************************
   assign rom_idx = bus.addr[`CMD_ROM_IDX_HI:`CMD_ROM_IDX_LO];
   // Small ROM answers its lower half only.
   assign rom_hit = ~bus.io_m & ~bus.read_strobe_n & ~bus.addr[15] &
      ~(rom_idx == `CMD_ROM_SMALL_IDX && bus.addr[`CMD_ROM_SMALL_BIT]);

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.rom_select_n <= 4'hF;
         bus.rom_addr <= 13'h0000;
      end else begin
         bus.rom_select_n <= rom_hit ? ~one_hot(rom_idx) : 4'hF;
         bus.rom_addr <= bus.addr[12:0];
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.data_dir_to_mem <= 1'b0;
         bus.data_gate_to_cpu <= 1'b0;
      end else begin
         bus.data_dir_to_mem <= ~bus.write_strobe_n & bus.read_strobe_n;
         bus.data_gate_to_cpu <= ~bus.read_strobe_n;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         io_reg_wr <= 1'b0;
         io_reg_rd <= 1'b0;
         io_reg_index <= 7'h00;
      end else begin
         io_reg_wr <= bus.io_m & ~bus.write_strobe_n;
         io_reg_rd <= bus.io_m & ~bus.read_strobe_n;
         io_reg_index <= bus.addr[`CMD_REG_IDX_HI:0];
      end
   end

endmodule
`default_nettype wire

/* File: rtl/cmd_master.sv */
`include "cmd_defs.svh"
`default_nettype none
// ****************************************
// Processor end issuing memory, ROM and I/O cycles.
// ****************************************
module cmd_master (
   input wire logic mclk,
   input wire logic srst,
   cmd_if.master bus,
   input wire logic adv_mode,
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic cmd_io,
   input wire logic [15:0] cmd_addr,
   output logic cmd_ready,
   output logic cmd_done,
   output logic early_ack
);

   // ****************************************
   // Declarations.
   // ****************************************
   cmd_pkg::cmd_host_state_t st;
   logic [2:0] cnt;
   logic [7:0] ref_cnt;
   logic ref_tick;
   logic take;
   logic to_ram;

   assign take = (st == cmd_pkg::CMD_H_IDLE) & cmd_valid;
   assign to_ram = ~cmd_io & (cmd_addr[15:14] == `CMD_RAM_WINDOW);
   assign ref_tick = ref_cnt == 8'h00;

   // Refresh interval counter.
   always_ff @(posedge mclk) begin
      if (srst) begin
         ref_cnt <= 8'(`CMD_REF_PERIOD_CYC - 1);
      end else if (ref_tick) begin
         ref_cnt <= 8'(`CMD_REF_PERIOD_CYC - 1);
      end else begin
         ref_cnt <= ref_cnt - 8'h01;
      end
   end

   // Cycle sequencer.
   always_ff @(posedge mclk) begin
      if (srst) begin
         st <= cmd_pkg::CMD_H_IDLE;
         cnt <= 3'h0;
      end else begin
         case (st)
            cmd_pkg::CMD_H_IDLE: begin
               if (take) begin
                  if (adv_mode & ~cmd_write & to_ram) begin
                     st <= cmd_pkg::CMD_H_ALE;
                  end else if (to_ram) begin
                     st <= cmd_pkg::CMD_H_MEM;
                  end else begin
                     st <= cmd_pkg::CMD_H_FIX;
                     cnt <= 3'(`CMD_FIXED_CYC - 1);
                  end
               end
            end
            cmd_pkg::CMD_H_ALE: begin
               st <= cmd_pkg::CMD_H_MEM;
            end
            cmd_pkg::CMD_H_MEM: begin
               if (bus.transfer_acknowledge) begin
                  st <= cmd_pkg::CMD_H_END;
               end
            end
            cmd_pkg::CMD_H_FIX: begin
               if (cnt == 3'h0) begin
                  st <= cmd_pkg::CMD_H_END;
               end else begin
                  cnt <= cnt - 3'h1;
               end
            end
            cmd_pkg::CMD_H_END: begin
               st <= cmd_pkg::CMD_H_IDLE;
            end
            default: begin
               st <= cmd_pkg::CMD_H_IDLE;
            end
         endcase
      end
   end

   // Active low strobes held for the cycle.
   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.addr <= 16'h0000;
         bus.io_m <= 1'b0;
         bus.read_strobe_n <= 1'b1;
         bus.write_strobe_n <= 1'b1;
         bus.read_request_status <= 1'b1;
         bus.protected_chip_select_n <= 1'b1;
         bus.bank_select_lo <= 1'b0;
         bus.bank_select_hi_strap <= 1'b0;
      end else if (take) begin
         bus.addr <= cmd_addr;
         bus.io_m <= cmd_io;
         bus.read_strobe_n <= cmd_write;
         bus.write_strobe_n <= ~cmd_write;
         bus.read_request_status <= adv_mode ? ~cmd_write : cmd_write;
         bus.protected_chip_select_n <= 1'b0;
         bus.bank_select_lo <= cmd_addr[14];
         bus.bank_select_hi_strap <= adv_mode | cmd_addr[15];
      end else if (st == cmd_pkg::CMD_H_END) begin
         bus.read_strobe_n <= 1'b1;
         bus.write_strobe_n <= 1'b1;
         bus.read_request_status <= ~adv_mode;
         bus.protected_chip_select_n <= 1'b1;
      end
   end

   // Latch strobe in advanced mode, refresh in normal.
   always_ff @(posedge mclk) begin
      if (srst) begin
         bus.refresh_or_latch_in <= 1'b0;
      end else if (adv_mode) begin
         bus.refresh_or_latch_in <= take & ~cmd_write & to_ram;
      end else begin
         bus.refresh_or_latch_in <= ref_tick;
      end
   end

   // User handshake.
   always_ff @(posedge mclk) begin
      if (srst) begin
         cmd_ready <= 1'b0;
         cmd_done <= 1'b0;
         early_ack <= 1'b0;
      end else begin
         cmd_ready <= (st == cmd_pkg::CMD_H_IDLE & ~take) | (st == cmd_pkg::CMD_H_END);
         cmd_done <= st == cmd_pkg::CMD_H_END;
         early_ack <= bus.system_acknowledge;
      end
   end

endmodule
`default_nettype wire

/* File: test/cmd_chk.sv */
`default_nettype none
// ****************************************
// Interface checker for the memory bus.
// ****************************************
module cmd_chk (
   input wire logic mclk,
   input wire logic srst,
   input wire logic [15:0] addr,
   input wire logic io_m,
   input wire logic read_strobe_n,
   input wire logic write_strobe_n,
   input wire logic [3:0] row_strobe_n,
   input wire logic col_strobe_n,
   input wire logic write_enable_n,
   input wire logic [8:0] dram_addr,
   input wire logic [3:0] rom_select_n,
   input wire logic [12:0] rom_addr,
   input wire logic system_acknowledge,
   input wire logic transfer_acknowledge
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   // Access start: row strobe falls from idle onto the RAM bank.
   sequence row_start_s;
      row_strobe_n == 4'hB && $past(row_strobe_n) == 4'hF;
   endsequence

   transfer_acknowledge_after_col_a: assert property (
      $fell(col_strobe_n) |-> ##2 transfer_acknowledge)
      else $error("transfer ack not two cycles after column strobe");
   col_address_a: assert property (
      $fell(col_strobe_n) |-> dram_addr == addr[15:7])
      else $error("column address wrong");
   row_address_a: assert property (
      row_start_s |-> dram_addr == {2'h0, addr[6:0]})
      else $error("row address wrong");
   ram_window_a: assert property (
      $fell(col_strobe_n) |-> (addr[15:14] == 2'h2 && !io_m))
      else $error("memory cycle outside the RAM window");
   system_acknowledge_bank_a: assert property (
      system_acknowledge && !transfer_acknowledge |-> row_strobe_n == 4'hB)
      else $error("system ack without bank two row strobe");
   row_hold_a: assert property (
      row_start_s |-> row_strobe_n == 4'hB [*4] ##1
      (transfer_acknowledge && row_strobe_n == 4'hB) ##1 row_strobe_n == 4'hF)
      else $error("row strobe span wrong");
   write_enable_a: assert property (
      !write_enable_n |-> (!write_strobe_n && !col_strobe_n))
      else $error("write enable without write request");
   transfer_acknowledge_pulse_a: assert property (
      transfer_acknowledge |=> !transfer_acknowledge)
      else $error("transfer ack longer than one cycle");
   refresh_len_a: assert property (
      row_strobe_n == 4'h0 && $past(row_strobe_n) != 4'h0 |->
      row_strobe_n == 4'h0 [*3] ##1 row_strobe_n != 4'h0)
      else $error("refresh length wrong");
   rom_on_a: assert property (
      !io_m && !read_strobe_n && !addr[15] && !(addr[14:13] == 2'h3 && addr[12]) |=>
      (rom_select_n == ~(4'h1 << $past(addr[14:13])) && rom_addr == $past(addr[12:0])))
      else $error("ROM select wrong");
   rom_off_a: assert property (
      !(!io_m && !read_strobe_n && !addr[15] && !(addr[14:13] == 2'h3 && addr[12])) |=>
      rom_select_n == 4'hF)
      else $error("ROM selected without ROM read");

   // Main scenarios seen.
   cover property ($fell(write_enable_n));
   cover property ($fell(col_strobe_n) && write_strobe_n);
   cover property (row_strobe_n == 4'h0);
   cover property (system_acknowledge && transfer_acknowledge);
endmodule
`default_nettype wire

/* File: test/cpu_memory_decode_dram_ctrl_tb.sv */
`default_nettype none
// ****************************************
// Bench joining both ends through one bus.
// ****************************************
module cpu_memory_decode_dram_ctrl_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic mclk, srst, strap, cmd_valid, cmd_write, cmd_io;
   logic [15:0] cmd_addr;
   logic cmd_ready, cmd_done, early_ack, adv_mode_o, io_reg_wr, io_reg_rd;
   logic [6:0] io_reg_index, io_idx;
   logic [3:0] rom_last;
   logic [12:0] rom_a;
   logic io_wr_seen, io_rd_seen, dir_seen, gate_seen;
   logic [31:0] rnd;
   int bad_count, comparisons, system_acknowledge_n, transfer_acknowledge_n, ref_n, lo01_n, eack_n;

   cmd_if bus();
   cmd_ctrl u_cmd_ctrl(.mclk(mclk), .srst(srst), .bus(bus), .advanced_strap(strap),
      .advanced_mode(adv_mode_o), .io_reg_wr(io_reg_wr), .io_reg_rd(io_reg_rd),
      .io_reg_index(io_reg_index));
   cmd_master u_cmd_master(.mclk(mclk), .srst(srst), .bus(bus), .adv_mode(strap),
      .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_io(cmd_io), .cmd_addr(cmd_addr),
      .cmd_ready(cmd_ready), .cmd_done(cmd_done), .early_ack(early_ack));
   cmd_chk u_cmd_chk(.mclk(mclk), .srst(srst), .addr(bus.addr), .io_m(bus.io_m),
      .read_strobe_n(bus.read_strobe_n), .write_strobe_n(bus.write_strobe_n),
      .row_strobe_n(bus.row_strobe_n), .col_strobe_n(bus.col_strobe_n),
      .write_enable_n(bus.write_enable_n), .dram_addr(bus.dram_addr),
      .rom_select_n(bus.rom_select_n), .rom_addr(bus.rom_addr),
      .system_acknowledge(bus.system_acknowledge),
      .transfer_acknowledge(bus.transfer_acknowledge));

   // Clock of 100 ns period.
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // Next pseudo random value.
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // Expected ROM select; the upper 4K of the last ROM is empty.
   function automatic logic [3:0] exp_rom(input logic [15:0] a);
      if (a[14:13] == 2'h3 && a[12]) return 4'hF;
      return ~(4'h1 << a[14:13]);
   endfunction

   // Compares one value and counts the outcome.
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic step();
      @(posedge mclk);
      #10;
   endtask

   // Watches acknowledges, refresh, ROM, data steering and I/O strobes.
   always @(posedge mclk) begin
      if (bus.system_acknowledge === 1'b1) system_acknowledge_n++;
      if (bus.transfer_acknowledge === 1'b1) transfer_acknowledge_n++;
      if (early_ack === 1'b1) eack_n++;
      if (bus.row_strobe_n === 4'h0 && $past(bus.row_strobe_n) !== 4'h0) ref_n++;
      if (bus.row_strobe_n[1:0] !== 2'h3) lo01_n++;
      if (bus.rom_select_n !== 4'hF) begin
         rom_last = bus.rom_select_n;
         rom_a = bus.rom_addr;
      end
      if (bus.data_dir_to_mem === 1'b1) dir_seen = 1'b1;
      if (bus.data_gate_to_cpu === 1'b1) gate_seen = 1'b1;
      if (io_reg_wr === 1'b1) io_wr_seen = 1'b1;
      if (io_reg_rd === 1'b1) io_rd_seen = 1'b1;
      if (io_reg_wr === 1'b1 || io_reg_rd === 1'b1) io_idx = io_reg_index;
   end

   // Issues one cycle and checks what it caused.
   task automatic do_op(input logic w, input logic io, input logic [15:0] a);
      int i, s0, x0, e0;
      logic ram;
      for (i = 0; i < 100 && cmd_ready !== 1'b1; i++) step();
      // Lets the registered strobes of the previous cycle drain first.
      repeat (2) step();
      s0 = system_acknowledge_n;
      x0 = transfer_acknowledge_n;
      e0 = eack_n;
      rom_last = 4'hF;
      {io_wr_seen, io_rd_seen, dir_seen, gate_seen} = 4'h0;
      ram = !io && a[15:14] == 2'h2;
      cmd_valid = 1'b1;
      cmd_write = w;
      cmd_io = io;
      cmd_addr = a;
      step();
      cmd_valid = 1'b0;
      for (i = 0; i < 100 && cmd_done !== 1'b1; i++) step();
      check("cmd_done", cmd_done, 1'b1);
      check("transfer_acknowledge count", transfer_acknowledge_n - x0, ram);
      check("system_acknowledge count", system_acknowledge_n - s0, ram);
      check("early ack count", eack_n - e0, ram);
      if (ram && w) check("data toward memory", dir_seen, 1'b1);
      if (ram && !w) check("data toward cpu", gate_seen, 1'b1);
      if (!io && !w && !a[15]) check("rom select", rom_last, exp_rom(a));
      if (!io && !w && !a[15] && exp_rom(a) != 4'hF) check("rom addr", rom_a, a[12:0]);
      check("io write", io_wr_seen, io && w);
      check("io read", io_rd_seen, io && !w);
      if (io) check("io index", io_idx, a[6:0]);
   endtask

   task automatic phase(input logic s, input int n);
      int k;
      srst = 1'b1;
      strap = s;
      repeat (12) step();
      srst = 1'b0;
      step();
      check("advanced mode", adv_mode_o, s);
      ref_n = 0;
      lo01_n = 0;
      do_op(1'b1, 1'b0, 16'h8123);
      do_op(1'b0, 1'b0, 16'hBFFF);
      do_op(1'b1, 1'b0, 16'h8000);
      do_op(1'b0, 1'b0, 16'h0000);
      do_op(1'b0, 1'b0, 16'h2ABC);
      do_op(1'b0, 1'b0, 16'h4001);
      do_op(1'b0, 1'b0, 16'h6FFF);
      do_op(1'b0, 1'b0, 16'h7000);
      do_op(1'b1, 1'b1, 16'h0045);
      do_op(1'b0, 1'b1, 16'h0048);
      for (k = 0; k < n; k++) begin
         rnd = lfsr(rnd);
         case (rnd[1:0])
            2'h0, 2'h1: do_op(rnd[2], 1'b0, {2'h2, rnd[29:16]});
            2'h2: do_op(1'b0, 1'b0, {1'b0, rnd[30:16]});
            default: do_op(rnd[2], 1'b1, {9'h000, rnd[22:16]});
         endcase
      end
      repeat (400) step();
   endtask

   // Normal mode run, then advanced read mode after a second reset.
   initial begin
      {srst, strap, cmd_valid, cmd_write, cmd_io} = 5'h10;
      cmd_addr = 16'h0000;
      {bad_count, comparisons, system_acknowledge_n, transfer_acknowledge_n, ref_n, lo01_n, eack_n} = '0;
      rnd = 32'h5E540AF4;
      phase(1'b0, 40);
      check("refresh seen", ref_n > 0, 1'b1);
      phase(1'b1, 20);
      check("advanced refresh", ref_n, 0);
      check("advanced low strobes", lo01_n, 0);
      final_report();
   end

   // Cuts a hung run short.
   initial begin
      #(100 * 20000);
      bad_count++;
      final_report();
   end
endmodule
`default_nettype wire
